// ---- ppcs_byte_flags.sv ----
`timescale 1ns/1ps
module ppcs_byte_flags #(
  parameter logic [3:0] INIT = 4'h0
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Per-byte set, per-word clear
  input wire logic [3:0] i_set,
  input wire logic [1:0] i_clr_pair,
  // Flags
  output logic [3:0] o_flags
);
  ppcs_pkg::ppcs_flags_st_t st;
  ppcs_pkg::ppcs_flags_st_t next_st;

  always_comb begin
    next_st = st;
    if (i_clr_pair[0]) begin
      next_st.flags[1:0] = 2'h0;
    end
    if (i_clr_pair[1]) begin
      next_st.flags[3:2] = 2'h0;
    end
    // Set after clear so an event in the clearing cycle survives
    next_st.flags = next_st.flags | i_set;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      st.flags <= INIT;
    end else begin
      st <= next_st;
    end
  end

  assign o_flags = st.flags;
endmodule // ppcs_byte_flags

// ---- ppcs_mem_model.sv ----
`timescale 1ns/1ps
module ppcs_mem_model (
  // Port pins
  input wire logic i_clk_sys,
  input wire ppcs_pkg::ppcs_pin_out_t i_pin,
  // Bench controls
  input wire logic i_ack_hi,
  input wire logic i_mute,
  input wire logic [3:0] i_ack_dly,
  // Answers
  output logic [15:0] o_rdata = 16'h0,
  output logic o_ack
);
  logic [15:0] mem [logic [23:0]];
  int n = 0;
  always @(posedge i_clk_sys) begin
    n = (i_pin.rd_strobe || i_pin.wr_strobe) ? n + 1 : 0;
    if (i_pin.wr_strobe) mem[i_pin.addr] = i_pin.wdata;
    // Released bus toggles so stale data never matches
    o_rdata <= !i_pin.rd_strobe ? ~o_rdata : mem.exists(i_pin.addr) ? mem[i_pin.addr] : 16'h5a5a;
    o_ack <= i_ack_hi ^ (i_mute || n < i_ack_dly);
  end
endmodule // ppcs_mem_model

// ---- ppcs_phase_timer.sv ----
`timescale 1ns/1ps
module ppcs_phase_timer (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Load a phase length in clocks
  input wire logic i_load,
  input wire logic [ppcs_pkg::CNT_W-1:0] i_count,
  // High in the last clock of the phase
  output logic o_last
);
  ppcs_pkg::ppcs_timer_st_t st;
  ppcs_pkg::ppcs_timer_st_t next_st;

  always_comb begin
    next_st = st;
    if (i_load) begin
      next_st.cnt = i_count;
    end else if (st.cnt != '0) begin
      next_st.cnt = st.cnt - ppcs_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_last = (st.cnt == ppcs_pkg::CNT_W'(1));
endmodule // ppcs_phase_timer

// ---- ppcs_pkg.sv ----
package ppcs_pkg;

  // Clock and instruction-cycle timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TCY_NS = 200;
  localparam int unsigned QTR_NS = TCY_NS / 4;
  localparam int unsigned QTR_CLKS = (QTR_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned QTR_PER_TCY = 4;
  localparam int unsigned CNT_W = 11;

  // Phase lengths in quarter cycles, gap and time-out in instruction cycles
  localparam int unsigned ADDR_QTRS = 4;
  localparam int unsigned SETUP_BASE_QTRS = 1;
  localparam int unsigned STROBE_WR_BASE_QTRS = 2;
  localparam int unsigned STROBE_RD_BASE_QTRS = 3;
  localparam int unsigned HOLD_WR_BASE_QTRS = 1;
  localparam int unsigned HOLD_RD_BASE_QTRS = 0;
  localparam int unsigned GAP_BASE_TCY = 3;
  localparam int unsigned TIMEOUT_DEFAULT_TCY = 255;

  // Register byte offsets
  localparam logic [7:0] REG_CS1_BASE = 8'h00;
  localparam logic [7:0] REG_CS2_BASE = 8'h04;
  localparam logic [7:0] REG_CS1_MODE = 8'h08;
  localparam logic [7:0] REG_CS2_MODE = 8'h0c;
  localparam logic [7:0] REG_CS1_CFG = 8'h10;
  localparam logic [7:0] REG_CS2_CFG = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_PAD = 8'h1c;
  localparam logic [7:0] REG_CTRL = 8'h20;
  localparam logic [7:0] REG_MADDR = 8'h24;
  localparam logic [7:0] REG_MWDATA = 8'h28;
  localparam logic [7:0] REG_MRDATA = 8'h2c;
  localparam logic [7:0] REG_IN_BUF = 8'h30;
  localparam logic [7:0] REG_OUT_BUF = 8'h34;

  // Reset values
  localparam logic [15:0] CS1_BASE_RESET = 16'h0080;
  localparam logic [15:0] CS2_BASE_RESET = 16'h0880;
  localparam logic [3:0] OUT_EMPTY_RESET = 4'hf;
  localparam logic [3:0] IN_FULL_RESET = 4'h0;

  // Field positions
  localparam int unsigned BASE_LSB = 7;
  localparam int unsigned HS_MODE_LSB = 14;
  localparam int unsigned AMW_LSB = 11;
  localparam int unsigned SETUP_LSB = 6;
  localparam int unsigned STROBE_LSB = 2;
  localparam int unsigned HOLD_LSB = 0;
  localparam logic [15:0] MODE_MASK = 16'hf8ff;
  localparam int unsigned POL_BIT = 7;
  localparam int unsigned ST_IN_ALL = 15;
  localparam int unsigned ST_IN_OVF = 14;
  localparam int unsigned ST_IN_SLOT = 8;
  localparam int unsigned ST_OUT_ALL = 7;
  localparam int unsigned ST_OUT_UNF = 6;
  localparam int unsigned ST_OUT_SLOT = 0;
  localparam int unsigned CTRL_GO = 0;
  localparam int unsigned CTRL_READ = 1;
  localparam int unsigned CTRL_SLAVE = 8;
  localparam int unsigned CTRL_TIMEOUT = 12;
  localparam int unsigned CTRL_BUSY = 15;

  // Handshake codes
  localparam logic [1:0] HS_NONE = 2'h0;
  localparam logic [1:0] HS_TIMED = 2'h1;
  localparam logic [1:0] HS_WAIT = 2'h2;

  typedef enum logic [2:0] {
    PH_IDLE, PH_ADDR, PH_SETUP, PH_STROBE, PH_ACKW, PH_HOLD, PH_GAP
  } ppcs_phase_t;

  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } ppcs_av_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } ppcs_av_rsp_t;

  typedef struct packed {
    logic cs1;
    logic cs2;
    logic rd_strobe;
    logic wr_strobe;
    logic data_oe;
    logic [23:0] addr;
    logic [15:0] wdata;
  } ppcs_pin_out_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] sel;
    logic [7:0] wdata;
  } ppcs_host_req_t;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } ppcs_timer_st_t;

  typedef struct packed {
    logic [3:0] flags;
  } ppcs_flags_st_t;

endpackage

// ---- ppcs_props.sv ----
`timescale 1ns/1ps
module ppcs_props (
  // Watched ports
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire ppcs_pkg::ppcs_av_req_t i_av,
  input wire ppcs_pkg::ppcs_av_rsp_t o_av,
  input wire ppcs_pkg::ppcs_pin_out_t o_pin,
  input wire logic o_pad_threshold_select
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  logic pad_wr;
  always_ff @(posedge i_clk_sys) begin
    pad_wr <= i_av.write && !o_av.waitrequest && i_av.address == ppcs_pkg::REG_PAD;
  end
  AST_BUS_WAIT: assert property ($rose(i_av.read || i_av.write) |->
    o_av.waitrequest ##1 !o_av.waitrequest) else $error("bus wait not one cycle");
  AST_PAD_WR: assert property ($changed(o_pad_threshold_select) |-> pad_wr)
    else $error("pad select moved without write");
  AST_STB_EXCL: assert property (!(o_pin.rd_strobe && o_pin.wr_strobe))
    else $error("both strobes active");
  AST_WR_LEN: assert property ($rose(o_pin.wr_strobe) |-> o_pin.wr_strobe[*2])
    else $error("write strobe too short");
  AST_RD_LEN: assert property ($rose(o_pin.rd_strobe) |-> o_pin.rd_strobe[*3])
    else $error("read strobe too short");
  AST_SETUP: assert property ($rose(o_pin.wr_strobe) |-> $past(o_pin.data_oe))
    else $error("no data before write strobe");
  AST_ADDR: assert property ($rose(o_pin.cs1 || o_pin.cs2) |->
    (!(o_pin.rd_strobe || o_pin.wr_strobe))[*5]) else $error("address phase short");
  AST_GAP: assert property ($fell(o_pin.cs1 || o_pin.cs2) |->
    (!(o_pin.cs1 || o_pin.cs2))[*8]) else $error("gap too short");
  AST_RD_NO_OE: assert property (o_pin.rd_strobe |-> !o_pin.data_oe)
    else $error("data driven during read");
endmodule // ppcs_props
bind ppcs_top ppcs_props props_u (.i_clk_sys, .i_reset, .i_av, .o_av, .o_pin,
  .o_pad_threshold_select);

// ---- ppcs_top.sv ----
`timescale 1ns/1ps
module ppcs_top (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Register bus
  input wire ppcs_pkg::ppcs_av_req_t i_av,
  output ppcs_pkg::ppcs_av_rsp_t o_av,
  // Master-mode pins
  output ppcs_pkg::ppcs_pin_out_t o_pin,
  input wire logic [15:0] i_pin_rdata,
  input wire logic i_ext_ack_input,
  // Slave-mode host access
  input wire ppcs_pkg::ppcs_host_req_t i_host,
  output logic [7:0] o_host_rdata,
  // Pad control
  output logic o_pad_threshold_select
);
  typedef struct packed {
    logic [8:0] cs1_base;
    logic [8:0] cs2_base;
    logic cs2_zeroed;
    logic [15:0] cs1_mode;
    logic [15:0] cs2_mode;
    logic cs1_pol;
    logic cs2_pol;
    logic pad_ttl;
    logic slave_mode;
    logic in_ovf;
    logic out_unf;
    logic timeout;
    logic bus_done;
    logic [31:0] rdata;
    logic [31:0] in_buf;
    logic [31:0] out_buf;
    logic [7:0] host_rdata;
    ppcs_pkg::ppcs_phase_t phase;
    logic dir_read;
    logic hit_cs1;
    logic hit_cs2;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic [15:0] mrdata;
    ppcs_pkg::ppcs_pin_out_t pins;
  } ppcs_top_st_t;

  ppcs_top_st_t st;
  ppcs_top_st_t next_st;
  logic t_load;
  logic [ppcs_pkg::CNT_W-1:0] t_count;
  logic t_last;
  logic [3:0] in_set;
  logic [1:0] in_clr;
  logic [3:0] out_set;
  logic [1:0] out_clr;
  logic [3:0] in_full;
  logic [3:0] out_empty;

  ppcs_phase_timer u_timer (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_load(t_load),
    .i_count(t_count),
    .o_last(t_last)
  );

  ppcs_byte_flags #(.INIT(ppcs_pkg::IN_FULL_RESET)) u_in_flags (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_set(in_set),
    .i_clr_pair(in_clr),
    .o_flags(in_full)
  );

  // output empty flags, all set at reset
  ppcs_byte_flags #(.INIT(ppcs_pkg::OUT_EMPTY_RESET)) u_out_flags (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_set(out_set),
    .i_clr_pair(out_clr),
    .o_flags(out_empty)
  );

  function automatic logic [ppcs_pkg::CNT_W-1:0] qclk(input int unsigned qtrs);
    qclk = ppcs_pkg::CNT_W'(qtrs * ppcs_pkg::QTR_CLKS);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  logic [15:0] status_word;
  logic [15:0] ctrl_word;
  logic [31:0] rd_word;

  always_comb begin
    // summary flags follow the byte flags
    // empty summary only when every byte is empty
    status_word = '0;
    status_word[ppcs_pkg::ST_IN_ALL] = &in_full;
    status_word[ppcs_pkg::ST_IN_OVF] = st.in_ovf;
    status_word[ppcs_pkg::ST_IN_SLOT +: 4] = in_full;
    status_word[ppcs_pkg::ST_OUT_ALL] = &out_empty;
    status_word[ppcs_pkg::ST_OUT_UNF] = st.out_unf;
    status_word[ppcs_pkg::ST_OUT_SLOT +: 4] = out_empty;
    ctrl_word = '0;
    ctrl_word[ppcs_pkg::CTRL_BUSY] = (st.phase != ppcs_pkg::PH_IDLE);
    ctrl_word[ppcs_pkg::CTRL_TIMEOUT] = st.timeout;
    ctrl_word[ppcs_pkg::CTRL_SLAVE] = st.slave_mode;
    ctrl_word[ppcs_pkg::CTRL_READ] = st.dir_read;
    rd_word = '0;
    case (i_av.address)
      ppcs_pkg::REG_CS1_BASE: rd_word[15:0] = {st.cs1_base, 7'h00};
      ppcs_pkg::REG_CS2_BASE: rd_word[15:0] = {st.cs2_base, 7'h00};
      ppcs_pkg::REG_CS1_MODE: rd_word[15:0] = st.cs1_mode;
      ppcs_pkg::REG_CS2_MODE: rd_word[15:0] = st.cs2_mode;
      ppcs_pkg::REG_CS1_CFG: rd_word[ppcs_pkg::POL_BIT] = st.cs1_pol;
      ppcs_pkg::REG_CS2_CFG: rd_word[ppcs_pkg::POL_BIT] = st.cs2_pol;
      ppcs_pkg::REG_STATUS: rd_word[15:0] = status_word;
      ppcs_pkg::REG_PAD: rd_word[0] = st.pad_ttl;
      ppcs_pkg::REG_CTRL: rd_word[15:0] = ctrl_word;
      ppcs_pkg::REG_MADDR: rd_word[23:0] = st.addr;
      ppcs_pkg::REG_MWDATA: rd_word[15:0] = st.wdata;
      ppcs_pkg::REG_MRDATA: rd_word[15:0] = st.mrdata;
      ppcs_pkg::REG_IN_BUF: rd_word = st.in_buf;
      ppcs_pkg::REG_OUT_BUF: rd_word = st.out_buf;
      default: rd_word = '0;
    endcase
  end

  logic acc;
  logic sw_wr;
  logic sw_rd;
  logic idle;
  logic go;
  logic hit2;
  logic hit1;
  logic [15:0] mode;
  logic pol;
  logic ack_on;
  logic [1:0] hs;
  logic [3:0] sw;
  logic [31:0] wd;
  logic [3:0] be;
  logic [15:0] tmp;
  logic host_wr;
  logic host_rd;
  logic act;

  always_comb begin
    next_st = st;
    t_load = 1'b0;
    t_count = '0;
    in_set = '0;
    in_clr = '0;
    out_set = '0;
    out_clr = '0;
    go = 1'b0;
    tmp = '0;
    wd = i_av.writedata;
    be = i_av.byteenable;
    acc = i_av.read | i_av.write;
    idle = (st.phase == ppcs_pkg::PH_IDLE);
    // One wait cycle: data latched first, effects at the release edge
    next_st.bus_done = acc & ~st.bus_done;
    if (acc & ~st.bus_done) begin
      next_st.rdata = rd_word;
    end
    sw_wr = acc & st.bus_done & i_av.write;
    sw_rd = acc & st.bus_done & i_av.read;

    if (sw_wr) begin
      case (i_av.address)
        ppcs_pkg::REG_CS1_BASE: begin
          tmp = merge16({st.cs1_base, 7'h00}, wd, be);
          next_st.cs1_base = tmp[15:ppcs_pkg::BASE_LSB];
        end
        ppcs_pkg::REG_CS2_BASE: begin
          tmp = merge16({st.cs2_base, 7'h00}, wd, be);
          next_st.cs2_base = tmp[15:ppcs_pkg::BASE_LSB];
          // only a full-width zero write counts
          next_st.cs2_zeroed = (be[1:0] == 2'h3) && (wd[15:0] == 16'h0000);
        end
        ppcs_pkg::REG_CS1_MODE: begin
          next_st.cs1_mode = merge16(st.cs1_mode, wd, be) & ppcs_pkg::MODE_MASK;
        end
        ppcs_pkg::REG_CS2_MODE: begin
          next_st.cs2_mode = merge16(st.cs2_mode, wd, be) & ppcs_pkg::MODE_MASK;
        end
        ppcs_pkg::REG_CS1_CFG: begin
          if (be[0]) next_st.cs1_pol = wd[ppcs_pkg::POL_BIT];
        end
        ppcs_pkg::REG_CS2_CFG: begin
          if (be[0]) next_st.cs2_pol = wd[ppcs_pkg::POL_BIT];
        end
        ppcs_pkg::REG_STATUS: begin
          if (be[1]) next_st.in_ovf = wd[ppcs_pkg::ST_IN_OVF];
          if (be[0]) next_st.out_unf = wd[ppcs_pkg::ST_OUT_UNF];
        end
        ppcs_pkg::REG_PAD: begin
          if (be[0]) next_st.pad_ttl = wd[0];
        end
        ppcs_pkg::REG_CTRL: begin
          if (be[1]) begin
            next_st.slave_mode = wd[ppcs_pkg::CTRL_SLAVE];
            if (!wd[ppcs_pkg::CTRL_TIMEOUT]) next_st.timeout = 1'b0;
          end
          if (be[0] && idle) begin
            next_st.dir_read = wd[ppcs_pkg::CTRL_READ];
            go = wd[ppcs_pkg::CTRL_GO] & ~st.slave_mode;
          end
        end
        ppcs_pkg::REG_MADDR: begin
          if (idle) begin
            if (be[0]) next_st.addr[7:0] = wd[7:0];
            if (be[1]) next_st.addr[15:8] = wd[15:8];
            if (be[2]) next_st.addr[23:16] = wd[23:16];
          end
        end
        ppcs_pkg::REG_MWDATA: begin
          if (idle) next_st.wdata = merge16(st.wdata, wd, be);
        end
        ppcs_pkg::REG_OUT_BUF: begin
          for (int i = 0; i < 4; i++) begin
            if (be[i]) next_st.out_buf[8*i +: 8] = wd[8*i +: 8];
          end
          // writing any byte of a word clears the empty flags of its whole word
          out_clr = {be[3] | be[2], be[1] | be[0]};
        end
        default: begin
        end
      endcase
    end
    if (sw_rd && (i_av.address == ppcs_pkg::REG_IN_BUF)) begin
      // byte read clears its whole word
      in_clr = {be[3] | be[2], be[1] | be[0]};
    end

    // host traffic acts only in slave mode
    host_wr = i_host.wr & st.slave_mode;
    host_rd = i_host.rd & st.slave_mode & ~i_host.wr;
    if (host_wr) begin
      if (in_full[i_host.sel]) begin
        next_st.in_ovf = 1'b1;
      end else begin
        next_st.in_buf[8*i_host.sel +: 8] = i_host.wdata;
      end
      in_set[i_host.sel] = 1'b1;
    end
    if (host_rd) begin
      next_st.host_rdata = st.out_buf[8*i_host.sel +: 8];
      if (out_empty[i_host.sel]) next_st.out_unf = 1'b1;
      out_set[i_host.sel] = 1'b1;
    end

    // region decode on address bits 23 to 15
    // zeroed second base disables it and caps the first region
    hit2 = ~st.cs2_zeroed && (st.addr[23:15] >= st.cs2_base);
    hit1 = ~hit2 && (st.addr[23:15] >= st.cs1_base) &&
           (!st.cs2_zeroed || (st.addr[23:20] == 4'h0));
    mode = st.hit_cs2 ? st.cs2_mode : st.cs1_mode;
    pol = st.hit_cs2 ? st.cs2_pol : st.cs1_pol;
    // acknowledge active level per chip select
    ack_on = (i_ext_ack_input == pol);
    hs = mode[ppcs_pkg::HS_MODE_LSB +: 2];
    sw = mode[ppcs_pkg::STROBE_LSB +: 4];

    // address, setup, strobe, hold in quarter steps
    case (st.phase)
      ppcs_pkg::PH_IDLE: begin
        if (go) begin
          next_st.hit_cs1 = hit1;
          next_st.hit_cs2 = hit2;
          t_load = 1'b1;
          t_count = qclk(ppcs_pkg::ADDR_QTRS);
          next_st.phase = ppcs_pkg::PH_ADDR;
        end
      end
      ppcs_pkg::PH_ADDR: begin
        if (t_last) begin
          t_load = 1'b1;
          t_count = qclk(ppcs_pkg::SETUP_BASE_QTRS +
                         ppcs_pkg::QTR_PER_TCY * 32'(mode[ppcs_pkg::SETUP_LSB +: 2]));
          next_st.phase = ppcs_pkg::PH_SETUP;
        end
      end
      ppcs_pkg::PH_SETUP: begin
        if (t_last) begin
          t_load = 1'b1;
          t_count = qclk((st.dir_read ? ppcs_pkg::STROBE_RD_BASE_QTRS :
                          ppcs_pkg::STROBE_WR_BASE_QTRS) + ppcs_pkg::QTR_PER_TCY * 32'(sw));
          next_st.phase = ppcs_pkg::PH_STROBE;
        end
      end
      ppcs_pkg::PH_STROBE, ppcs_pkg::PH_ACKW: begin
        if (st.phase == ppcs_pkg::PH_STROBE && t_last &&
            (hs == ppcs_pkg::HS_WAIT || hs == ppcs_pkg::HS_TIMED)) begin
          t_load = 1'b1;
          t_count = qclk(ppcs_pkg::QTR_PER_TCY *
                         ((sw == 4'h0) ? ppcs_pkg::TIMEOUT_DEFAULT_TCY : 32'(sw)));
          next_st.phase = ppcs_pkg::PH_ACKW;
        end else if ((st.phase == ppcs_pkg::PH_STROBE && t_last) ||
                     (st.phase == ppcs_pkg::PH_ACKW && ack_on)) begin
          // completion on the strobe count or on acknowledge
          if (st.dir_read) next_st.mrdata = i_pin_rdata;
          // good completion clears the time-out flag
          next_st.timeout = 1'b0;
          t_count = qclk((st.dir_read ? ppcs_pkg::HOLD_RD_BASE_QTRS :
                          ppcs_pkg::HOLD_WR_BASE_QTRS) +
                         ppcs_pkg::QTR_PER_TCY * 32'(mode[ppcs_pkg::HOLD_LSB +: 2]));
          if (t_count == '0) begin
            t_count = qclk(ppcs_pkg::QTR_PER_TCY *
                           (ppcs_pkg::GAP_BASE_TCY + 32'(mode[ppcs_pkg::AMW_LSB +: 3])));
            next_st.phase = ppcs_pkg::PH_GAP;
          end else begin
            next_st.phase = ppcs_pkg::PH_HOLD;
          end
          t_load = 1'b1;
        end else if (st.phase == ppcs_pkg::PH_ACKW && hs == ppcs_pkg::HS_TIMED && t_last) begin
          // expired wait sets the flag and abandons
          next_st.timeout = 1'b1;
          t_load = 1'b1;
          t_count = qclk(ppcs_pkg::QTR_PER_TCY *
                         (ppcs_pkg::GAP_BASE_TCY + 32'(mode[ppcs_pkg::AMW_LSB +: 3])));
          next_st.phase = ppcs_pkg::PH_GAP;
        end
      end
      ppcs_pkg::PH_HOLD: begin
        if (t_last) begin
          t_load = 1'b1;
          t_count = qclk(ppcs_pkg::QTR_PER_TCY *
                         (ppcs_pkg::GAP_BASE_TCY + 32'(mode[ppcs_pkg::AMW_LSB +: 3])));
          next_st.phase = ppcs_pkg::PH_GAP;
        end
      end
      ppcs_pkg::PH_GAP: begin
        if (t_last) next_st.phase = ppcs_pkg::PH_IDLE;
      end
      default: next_st.phase = ppcs_pkg::PH_IDLE;
    endcase

    // Pins registered from the next phase to avoid decode glitches
    act = (next_st.phase != ppcs_pkg::PH_IDLE) && (next_st.phase != ppcs_pkg::PH_GAP);
    next_st.pins.cs1 = act & next_st.hit_cs1;
    next_st.pins.cs2 = act & next_st.hit_cs2;
    next_st.pins.rd_strobe = next_st.dir_read &&
      (next_st.phase == ppcs_pkg::PH_STROBE || next_st.phase == ppcs_pkg::PH_ACKW);
    next_st.pins.wr_strobe = !next_st.dir_read &&
      (next_st.phase == ppcs_pkg::PH_STROBE || next_st.phase == ppcs_pkg::PH_ACKW);
    next_st.pins.data_oe = !next_st.dir_read && act && (next_st.phase != ppcs_pkg::PH_ADDR);
    next_st.pins.addr = next_st.addr;
    next_st.pins.wdata = next_st.wdata;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      st <= '0;
      st.cs1_base <= ppcs_pkg::CS1_BASE_RESET[15:ppcs_pkg::BASE_LSB];
      st.cs2_base <= ppcs_pkg::CS2_BASE_RESET[15:ppcs_pkg::BASE_LSB];
      st.phase <= ppcs_pkg::PH_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign o_av.readdata = st.rdata;
  assign o_av.waitrequest = acc & ~st.bus_done;
  assign o_pin = st.pins;
  assign o_host_rdata = st.host_rdata;
  assign o_pad_threshold_select = st.pad_ttl;
endmodule // ppcs_top

// ---- tb_top.sv ----
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin bad_count++; \
  $display("BAD %s expected %h seen %h", n, e, s); end end
module tb_top;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  ppcs_pkg::ppcs_av_req_t av = '0;
  ppcs_pkg::ppcs_av_rsp_t rsp;
  ppcs_pkg::ppcs_pin_out_t pin;
  ppcs_pkg::ppcs_host_req_t host = '0;
  logic [15:0] rdata, wd, md;
  logic [31:0] q, v;
  logic [7:0] hrd, ob [4];
  logic [3:0] dly = 4'h0, be, inf = 4'h0, oute = 4'hf, m, okb = 4'h0;
  logic ack, pad, ack_hi = 1'b0, mute = 1'b0, ovf = 1'b0, unf = 1'b0, r;
  int bad_count, checks_done, st_n, su_n, ho_n, c1, c2, su, sw, hw, op, s;
  always #25 i_clk_sys = ~i_clk_sys;
  ppcs_top dut_u (.i_clk_sys, .i_reset, .i_av(av), .o_av(rsp), .o_pin(pin),
    .i_pin_rdata(rdata), .i_ext_ack_input(ack), .i_host(host), .o_host_rdata(hrd),
    .o_pad_threshold_select(pad));
  ppcs_mem_model mem_u (.i_clk_sys, .i_pin(pin), .i_ack_hi(ack_hi), .i_mute(mute),
    .i_ack_dly(dly), .o_rdata(rdata), .o_ack(ack));
  // Phase lengths seen on the pins
  always @(posedge i_clk_sys) begin
    if (pin.rd_strobe || pin.wr_strobe) st_n++;
    else if (pin.cs1 || pin.cs2) begin
      if (st_n == 0) su_n++;
      else ho_n++;
    end
    c1 |= pin.cs1;
    c2 |= pin.cs2;
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] b);
    av <= '{address: a, read: !w, write: w, writedata: d, byteenable: b};
    // Held until the edge that sees waitrequest low; data taken there
    do @(posedge i_clk_sys); while (rsp.waitrequest);
    q = rsp.readdata;
    av <= '0;
    @(posedge i_clk_sys);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] e, input string n);
    bus(0, a, 0, 4'hf);
    `CHK(n, e, q[15:0])
  endtask
  task automatic xfer(input logic [15:0] mode, input logic rd, input logic [23:0] ad);
    int k;
    bus(1, ppcs_pkg::REG_CS1_MODE, {16'h0, mode}, 4'hf);
    bus(1, ppcs_pkg::REG_MADDR, {8'h0, ad}, 4'hf);
    bus(1, ppcs_pkg::REG_MWDATA, {16'h0, wd}, 4'hf);
    {st_n, su_n, ho_n, c1, c2} = '0;
    bus(1, ppcs_pkg::REG_CTRL, {30'h0, rd, 1'b1}, 4'hf);
    k = 0;
    do begin
      bus(0, ppcs_pkg::REG_CTRL, 0, 4'hf);
      k++;
    end while (q[15] && k < 300);
    `CHK("busy end", 1'b0, q[15])
    if (rd) bus(0, ppcs_pkg::REG_MRDATA, 0, 4'hf);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #3000000;
    bad_count++;
    close_out();
  end
  initial begin
    void'($urandom(80116));
    repeat (16) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    @(posedge i_clk_sys);
    rchk(ppcs_pkg::REG_CS1_BASE, 16'h0080, "cs1 base");
    rchk(ppcs_pkg::REG_CS2_BASE, 16'h0880, "cs2 base");
    rchk(8'h3c, 16'h0, "unmapped");
    v = $urandom;
    bus(1, ppcs_pkg::REG_CS1_BASE, v, 4'hf);
    rchk(ppcs_pkg::REG_CS1_BASE, v[15:0] & 16'hff80, "base field");
    bus(1, ppcs_pkg::REG_CS1_BASE, 32'h80, 4'hf);
    bus(1, ppcs_pkg::REG_PAD, v, 4'hf);
    rchk(ppcs_pkg::REG_PAD, {15'h0, v[0]}, "pad reg");
    `CHK("pad pin", v[0], pad)
    wd = v[31:16];
    xfer(16'h0, 0, 24'h0f0000);
    `CHK("cs2 region", 2'b01, {c1[0], c2[0]})
    bus(1, ppcs_pkg::REG_CS2_BASE, 0, 4'h3);
    xfer(16'h0, 0, 24'h0f0000);
    `CHK("cs1 stretched", 2'b10, {c1[0], c2[0]})
    bus(1, ppcs_pkg::REG_CS2_BASE, 32'h880, 4'hf);
    for (int i = 0; i < 8; i++) begin
      su = $urandom % 4;
      sw = $urandom % 3;
      hw = $urandom % 4;
      r = i[0];
      md = {2'b00, 3'($urandom), 3'b000, su[1:0], sw[3:0], hw[1:0]};
      if (!r) wd = 16'($urandom);
      xfer(md, r, 24'h010000);
      `CHK("phases", {8'(3 * r + 2 * !r + 4 * sw), 8'(5 + 4 * su), 8'(4 * hw + !r)}, {st_n[7:0], su_n[7:0], ho_n[7:0]})
      if (r) `CHK("read data", wd, q[15:0])
    end
    for (int p = 0; p < 2; p++) begin
      bus(1, ppcs_pkg::REG_CS1_CFG, 32'(p) << 7, 4'hf);
      ack_hi <= p[0];
      dly <= 4'h9;
      wd = 16'($urandom);
      xfer(16'h8000, 0, 24'h020000);
      xfer(16'h8000, 1, 24'h020000);
      `CHK("ack data", wd, q[15:0])
      `CHK("ack wait", 1'b1, st_n > 8)
    end
    mute <= 1'b1;
    xfer(16'h4004, 0, 24'h020000);
    `CHK("timeout flag", 1'b1, q[12])
    `CHK("timeout span", 10, st_n)
    mute <= 1'b0;
    host <= '{wr: 1'b1, rd: 1'b0, sel: 2'h1, wdata: 8'h11};
    @(posedge i_clk_sys);
    host <= '0;
    @(posedge i_clk_sys);
    rchk(ppcs_pkg::REG_STATUS, 16'h008f, "master status");
    bus(1, ppcs_pkg::REG_CTRL, 32'h100, 4'hf);
    repeat (40) begin
      op = $urandom % 4;
      s = $urandom % 4;
      be = 4'($urandom % 15 + 1);
      v = $urandom;
      m = {{2{|be[3:2]}}, {2{|be[1:0]}}};
      if (op < 2) begin
        host <= '{wr: op == 0, rd: op == 1, sel: s[1:0], wdata: v[7:0]};
        @(posedge i_clk_sys);
        host <= '0;
        @(posedge i_clk_sys);
        if (op == 0) ovf |= inf[s];
        if (op == 0) inf[s] = 1'b1;
        if (op == 1 && !oute[s] && okb[s]) `CHK("host data", ob[s], hrd)
        if (op == 1) unf |= oute[s];
        if (op == 1) oute[s] = 1'b1;
      end else if (op == 2) begin
        bus(0, ppcs_pkg::REG_IN_BUF, 0, be);
        inf &= ~m;
      end else begin
        bus(1, ppcs_pkg::REG_OUT_BUF, v, be);
        oute &= ~m;
        for (int b = 0; b < 4; b++) if (be[b]) ob[b] = v[8 * b +: 8];
        okb |= be;
      end
      rchk(ppcs_pkg::REG_STATUS, {&inf, ovf, 2'b0, inf, &oute, unf, 2'b0, oute}, "status");
    end
    // Software clears both sticky bits
    bus(1, ppcs_pkg::REG_STATUS, 0, 4'hf);
    rchk(ppcs_pkg::REG_STATUS, {&inf, 3'b0, inf, &oute, 3'b0, oute}, "sticky");
    close_out();
  end
endmodule // tb_top
